// ### smp_consts.vh
// constants for the stepper motor pwm selector block
// assumes avalon-mm with 32-bit data, byte registers in the low lanes
`ifndef SMP_CONSTS_VH
`define SMP_CONSTS_VH

// ********************************
// register indices (byte address = 4 * index)
// ********************************
`define SMP_IDX_CONTROL     8'h23
`define SMP_IDX_SEL_ONE     8'h27
`define SMP_IDX_SEL_TWO     8'h28
`define SMP_IDX_CMP_ONE     8'h24
`define SMP_IDX_CMP_TWO     8'h25
`define SMP_IDX_TEST        8'h2D
`define SMP_IDX_STATUS      8'h2E

// ********************************
// reset values and field positions
// ********************************
`define SMP_RST_CONTROL     8'h00
`define SMP_RST_SEL         8'h00
`define SMP_RST_CMP         8'h00
`define SMP_RST_TEST        8'h02
`define SMP_CTL_PIN_TWO     7
`define SMP_CTL_PIN_ONE     6
`define SMP_CTL_PRE_HI      5
`define SMP_CTL_PRE_LO      4
`define SMP_CTL_RUN         3
`define SMP_CTL_TEST        0
`define SMP_CTL_MASK        8'hF9
`define SMP_SEL_MASK        8'h3F
`define SMP_SEL_STROBE      6
`define SMP_SEL_PLUS_HI     5
`define SMP_SEL_PLUS_LO     3
`define SMP_SEL_MINUS_HI    2
`define SMP_SEL_MINUS_LO    0
`define SMP_READ_ZERO       32'h0000_0000
`define SMP_UNMAPPED        32'hDEAD_BEEF

// ********************************
// counter and prescale codes
// ********************************
`define SMP_CNT_TOP         8'hFF
`define SMP_CNT_ZERO        8'h00
`define SMP_PRE_WIDTH       3
`define SMP_PRE_ZERO        3'h0
`define SMP_PRE_ONE         3'h1
`define SMP_PRE_DIV2        3'h1
`define SMP_PRE_DIV4        3'h3
`define SMP_PRE_DIV8        3'h7
`define SMP_PRE_SYS         3'h0

`endif

// ### smp_pulse_gen.v
// one 8-bit pwm comparator with its active compare value
// assumes counter and load strobe come from the same clock domain
`timescale 1ns/1ps
module smp_pulse_gen (
    input  wire       clock_in,      // system clock
    input  wire       rst_in,        // synchronous reset
    input  wire [7:0] count_in,      // shared counter value
    input  wire       run_in,        // counter running
    input  wire       load_in,       // take new compare value
    input  wire [7:0] compare_in,    // buffered compare value
    output reg        pulse_out      // pwm pulse
);
`include "smp_consts.vh"

// ********************************
// active compare and pulse
// ********************************
reg [7:0] active_cmp;                // compare value in use

// active value changes only on load
always @(posedge clock_in) begin
    if (rst_in) begin
        active_cmp <= `SMP_RST_CMP;
    end else if (load_in) begin
        active_cmp <= compare_in;
    end
end

// high while counter below compare, 0 gives zero high time
always @(posedge clock_in) begin
    if (rst_in) begin
        pulse_out <= 1'b0;
    end else begin
        pulse_out <= run_in & (count_in < active_cmp);
    end
end

endmodule

// ### smp_driver_sel.v
// selector of one coil end: low, high, pulse or released
// assumes select code is already the active, loaded value
`timescale 1ns/1ps
module smp_driver_sel (
    input  wire       clock_in,      // system clock
    input  wire       rst_in,        // synchronous reset
    input  wire [2:0] select_in,     // driver select code
    input  wire       pulse_in,      // generator pulse
    input  wire       pin_en_in,     // pin given to controller
    output reg        drive_out,     // driven level
    output reg        drive_oe_n_out // low while driving
);

// ********************************
// code decode
// ********************************
// 000 low, 001 high, 01x pulse, 1xx high impedance
always @(posedge clock_in) begin
    if (rst_in) begin
        drive_out      <= 1'b0;
        drive_oe_n_out <= 1'b1;
    end else begin
        drive_oe_n_out <= ~pin_en_in | select_in[2];
        if (select_in[1]) begin
            drive_out <= pulse_in;
        end else begin
            drive_out <= select_in[0];
        end
    end
end

endmodule

// ### smp_top.v
// top of the stepper motor pwm selector: registers, counter, two coils
// assumes an avalon-mm master on clock_in; pins are resolved outside
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps

module smp_top (
    input  wire        clock_in,             // system clock, 50 MHz
    input  wire        rst_in,               // synchronous reset
    input  wire [7:0]  avs_address_in,       // word address
    input  wire        avs_read_in,          // read request
    input  wire        avs_write_in,         // write request
    input  wire [31:0] avs_writedata_in,     // write data
    input  wire [3:0]  avs_byteenable_in,    // byte enables
    output reg  [31:0] avs_readdata_out,     // read data
    output reg         avs_waitrequest_out,  // stall
    output reg         coil_one_plus_output_out,   // coil one plus level
    output reg         coil_one_plus_oe_n_out,     // low while driving
    output reg         coil_one_minus_output_out,  // coil one minus level
    output reg         coil_one_minus_oe_n_out,    // low while driving
    output reg         coil_two_plus_output_out,   // coil two plus level
    output reg         coil_two_plus_oe_n_out,     // low while driving
    output reg         coil_two_minus_output_out,  // coil two minus level
    output reg         coil_two_minus_oe_n_out,    // low while driving
    output reg         coil_one_pin_enable_out,    // pins one to controller
    output reg         coil_two_pin_enable_out     // pins two to controller
);
`include "smp_consts.vh"

// ********************************
// registers
// ********************************
reg [7:0]  motor_pwm_control;        // control byte
reg [7:0]  coil_one_output_select;   // buffered select coil one
reg [7:0]  coil_two_output_select;   // buffered select coil two, strobe bit 6
reg [7:0]  coil_one_compare;         // buffered compare coil one
reg [7:0]  coil_two_compare;         // buffered compare coil two
reg [7:0]  selector_factory_test;    // factory test byte
reg [5:0]  active_sel_one;           // select codes in use, coil one
reg [5:0]  active_sel_two;           // select codes in use, coil two
reg [7:0]  count;                    // shared pwm counter
reg [2:0]  prescale;                 // prescale divider
reg        run_q;                    // run bit one clock ago
reg        pending_clear;            // strobe to clear at next period start
reg        busy;                     // bus answer phase

// decoded control fields and bus handshake
wire [7:0] sel_reset    = `SMP_SEL_MASK & `SMP_RST_SEL; // reset select byte
wire       run          = motor_pwm_control[`SMP_CTL_RUN];
wire [1:0] counter_clock_prescale = motor_pwm_control[`SMP_CTL_PRE_HI:`SMP_CTL_PRE_LO];
wire       buffer_strobe = coil_two_output_select[`SMP_SEL_STROBE];
wire       wr_go        = avs_write_in & busy;   // write accepted this edge
// read data load as the read is taken, so they stand at the answer edge
wire       rd_go        = avs_read_in & ~busy;   // read taken this edge
reg  [2:0] pre_top;                   // divider terminal value
wire       tick         = run & (prescale == pre_top);
wire       period_end   = tick & (count == `SMP_CNT_TOP);
wire       load         = period_end & buffer_strobe;
wire       strobe_write = wr_go & avs_byteenable_in[0] & (avs_address_in == `SMP_IDX_SEL_TWO);

// ********************************
// prescale decode
// ********************************
// divide select for counter clock
always @* begin
    // terminal value of the divider; a tick comes when it is reached
    case (counter_clock_prescale)
        2'b00:   pre_top = `SMP_PRE_SYS;
        2'b01:   pre_top = `SMP_PRE_DIV2;
        2'b10:   pre_top = `SMP_PRE_DIV4;
        default: pre_top = `SMP_PRE_DIV8;
    endcase
end

// ********************************
// shared counter
// ********************************
// counter restarts at zero on run rise, halts on clear
always @(posedge clock_in) begin
    if (rst_in) begin
        count    <= `SMP_CNT_ZERO;
        prescale <= `SMP_PRE_ZERO;
        run_q    <= 1'b0;
    end else begin
        run_q <= run;
        // a restart wins over a tick in the same cycle
        if (run & ~run_q) begin
            count    <= `SMP_CNT_ZERO;
            prescale <= `SMP_PRE_ZERO;
        end else if (tick) begin
            prescale <= `SMP_PRE_ZERO;
            count    <= count + 8'h01;    // wraps after 256
        end else if (run) begin
            prescale <= prescale + `SMP_PRE_ONE;
        end
    end
end

// ********************************
// setting load
// ********************************
// active selects change only at period end with strobe set
always @(posedge clock_in) begin
    if (rst_in) begin
        active_sel_one <= sel_reset[5:0];
        active_sel_two <= sel_reset[5:0];
    end else if (load) begin
        active_sel_one <= coil_one_output_select[5:0];
        active_sel_two <= coil_two_output_select[5:0];
    end
end

// ********************************
// bus slave and registers
// ********************************
// one wait state per access; strobe cleared at next period start
always @(posedge clock_in) begin
    if (rst_in) begin
        motor_pwm_control      <= `SMP_RST_CONTROL;
        coil_one_output_select <= `SMP_RST_SEL;
        coil_two_output_select <= `SMP_RST_SEL;
        coil_one_compare       <= `SMP_RST_CMP;
        coil_two_compare       <= `SMP_RST_CMP;
        selector_factory_test  <= `SMP_RST_TEST;
        pending_clear          <= 1'b0;
        busy                   <= 1'b0;
        avs_waitrequest_out    <= 1'b1;
        avs_readdata_out       <= `SMP_READ_ZERO;
    end else begin
        busy                <= (avs_read_in | avs_write_in) & ~busy;
        avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~busy);
        // hardware clear one tick after load, i.e. first count of new period
        if (load) begin
            pending_clear <= 1'b1;
        end else if (tick | strobe_write) begin
            pending_clear <= 1'b0;
        end
        // a strobe write in this cycle wins over the hardware clear; the bit takes the written value
        if (pending_clear & tick & ~strobe_write) begin
            coil_two_output_select[`SMP_SEL_STROBE] <= 1'b0;
        end
        // every writable register sits in byte lane 0; other lanes are ignored
        if (wr_go & avs_byteenable_in[0]) begin
            case (avs_address_in)
                `SMP_IDX_CONTROL: motor_pwm_control <= avs_writedata_in[7:0] & `SMP_CTL_MASK;
                `SMP_IDX_SEL_ONE: coil_one_output_select <= avs_writedata_in[7:0] & `SMP_SEL_MASK;
                `SMP_IDX_SEL_TWO: coil_two_output_select <= avs_writedata_in[7:0] & 8'h7F;
                `SMP_IDX_CMP_ONE: coil_one_compare <= avs_writedata_in[7:0];
                `SMP_IDX_CMP_TWO: coil_two_compare <= avs_writedata_in[7:0];
                `SMP_IDX_TEST:    selector_factory_test <= avs_writedata_in[7:0];
                default: ;
            endcase
        end
        // read data stand from the take edge until the next read is taken
        if (rd_go) begin
            case (avs_address_in)
                `SMP_IDX_CONTROL: avs_readdata_out <= {24'h000000, motor_pwm_control};
                `SMP_IDX_SEL_ONE: avs_readdata_out <= {24'h000000, coil_one_output_select};
                `SMP_IDX_SEL_TWO: avs_readdata_out <= {24'h000000, coil_two_output_select};
                `SMP_IDX_CMP_ONE: avs_readdata_out <= {24'h000000, coil_one_compare};
                `SMP_IDX_CMP_TWO: avs_readdata_out <= {24'h000000, coil_two_compare};
                `SMP_IDX_TEST:    avs_readdata_out <= {24'h000000, selector_factory_test};
                `SMP_IDX_STATUS:  avs_readdata_out <= {23'h000000, run, count};
                default:          avs_readdata_out <= `SMP_UNMAPPED;
            endcase
        end
    end
end

// ********************************
// generators and selectors
// ********************************
wire pulse_one;        // first generator pulse
wire pulse_two_early;  // second generator pulse before delay
reg  pulse_two;        // second pulse, one clock late
reg  [5:0] sel_two_d;  // select two delayed with its pulse
reg  pin_two_d;        // pin enable two delayed
// driver outputs: level and active-low enable per coil end
wire one_p;
wire one_pn;
wire one_m;
wire one_mn;
wire two_p;
wire two_pn;
wire two_m;
wire two_mn;

// first_pulse_generator
smp_pulse_gen u_gen_one (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .count_in   (count),
    .run_in     (run),
    .load_in    (load),
    .compare_in (coil_one_compare),
    .pulse_out  (pulse_one)
);

// second_pulse_generator
smp_pulse_gen u_gen_two (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .count_in   (count),
    .run_in     (run),
    .load_in    (load),
    .compare_in (coil_two_compare),
    .pulse_out  (pulse_two_early)
);

// delay the whole second coil path by one system clock
always @(posedge clock_in) begin
    if (rst_in) begin
        pulse_two <= 1'b0;
        sel_two_d <= sel_reset[5:0];
        pin_two_d <= 1'b0;
    end else begin
        pulse_two <= pulse_two_early;
        sel_two_d <= active_sel_two;
        pin_two_d <= motor_pwm_control[`SMP_CTL_PIN_TWO];
    end
end

// coil one plus end
smp_driver_sel u_one_plus (
    .clock_in       (clock_in),
    .rst_in         (rst_in),
    .select_in      (active_sel_one[`SMP_SEL_PLUS_HI:`SMP_SEL_PLUS_LO]),
    .pulse_in       (pulse_one),
    .pin_en_in      (motor_pwm_control[`SMP_CTL_PIN_ONE]),
    .drive_out      (one_p),
    .drive_oe_n_out (one_pn)
);
// coil one minus end
smp_driver_sel u_one_minus (
    .clock_in       (clock_in),
    .rst_in         (rst_in),
    .select_in      (active_sel_one[`SMP_SEL_MINUS_HI:`SMP_SEL_MINUS_LO]),
    .pulse_in       (pulse_one),
    .pin_en_in      (motor_pwm_control[`SMP_CTL_PIN_ONE]),
    .drive_out      (one_m),
    .drive_oe_n_out (one_mn)
);
// coil two plus end, one clock behind coil one
smp_driver_sel u_two_plus (
    .clock_in       (clock_in),
    .rst_in         (rst_in),
    .select_in      (sel_two_d[`SMP_SEL_PLUS_HI:`SMP_SEL_PLUS_LO]),
    .pulse_in       (pulse_two),
    .pin_en_in      (pin_two_d),
    .drive_out      (two_p),
    .drive_oe_n_out (two_pn)
);
// coil two minus end, one clock behind coil one
smp_driver_sel u_two_minus (
    .clock_in       (clock_in),
    .rst_in         (rst_in),
    .select_in      (sel_two_d[`SMP_SEL_MINUS_HI:`SMP_SEL_MINUS_LO]),
    .pulse_in       (pulse_two),
    .pin_en_in      (pin_two_d),
    .drive_out      (two_m),
    .drive_oe_n_out (two_mn)
);

// ********************************
// output flops
// ********************************
// every top output from a flop
always @(posedge clock_in) begin
    if (rst_in) begin
        // pins released and low until the first clock after reset
        coil_one_plus_output_out  <= 1'b0;
        coil_one_plus_oe_n_out    <= 1'b1;
        coil_one_minus_output_out <= 1'b0;
        coil_one_minus_oe_n_out   <= 1'b1;
        coil_two_plus_output_out  <= 1'b0;
        coil_two_plus_oe_n_out    <= 1'b1;
        coil_two_minus_output_out <= 1'b0;
        coil_two_minus_oe_n_out   <= 1'b1;
        coil_one_pin_enable_out   <= 1'b0;
        coil_two_pin_enable_out   <= 1'b0;
    end else begin
        coil_one_plus_output_out  <= one_p;
        coil_one_plus_oe_n_out    <= one_pn;
        coil_one_minus_output_out <= one_m;
        coil_one_minus_oe_n_out   <= one_mn;
        coil_two_plus_output_out  <= two_p;
        coil_two_plus_oe_n_out    <= two_pn;
        coil_two_minus_output_out <= two_m;
        coil_two_minus_oe_n_out   <= two_mn;
        // pin enables change one clock before their coil's driver enables
        coil_one_pin_enable_out   <= motor_pwm_control[`SMP_CTL_PIN_ONE];
        coil_two_pin_enable_out   <= pin_two_d;
    end
end

endmodule

// ### smp_top_asserts.sv
// checker of the smp_top bus handshake and pin release
// assumes it is bound onto smp_top, one clock domain
`timescale 1ns/1ps
`include "smp_consts.vh"
module smp_top_asserts (
    input logic        clock_in,
    input logic        rst_in,
    input logic [7:0]  avs_address_in,
    input logic        avs_read_in,
    input logic        avs_write_in,
    input logic [31:0] avs_readdata_out,
    input logic        avs_waitrequest_out,
    input logic        coil_one_plus_oe_n_out,
    input logic        coil_one_minus_oe_n_out,
    input logic        coil_two_plus_oe_n_out,
    input logic        coil_two_minus_oe_n_out,
    input logic        coil_one_pin_enable_out,
    input logic        coil_two_pin_enable_out
);
    // ********************************
    // helper logic
    // ********************************
    wire req    = avs_read_in || avs_write_in;  // any request
    wire mapped = avs_address_in == `SMP_IDX_CONTROL || avs_address_in == `SMP_IDX_SEL_ONE
        || avs_address_in == `SMP_IDX_SEL_TWO || avs_address_in == `SMP_IDX_CMP_ONE
        || avs_address_in == `SMP_IDX_CMP_TWO || avs_address_in == `SMP_IDX_TEST
        || avs_address_in == `SMP_IDX_STATUS;  // known register index
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // ********************************
    // properties
    // ********************************
    AST_RESET_IDLE: assert property (disable iff (1'b0) rst_in |=> avs_waitrequest_out
        && avs_readdata_out == 32'h0 && !coil_one_pin_enable_out && !coil_two_pin_enable_out)
        else $error("reset state wrong");
    AST_ONE_WAIT: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("request not answered after one wait state");
    AST_WAIT_CAUSE: assert property (!avs_waitrequest_out |-> $past(req))
        else $error("answer without request");
    AST_WAIT_PULSE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer longer than one cycle");
    AST_UNMAPPED_READ: assert property (avs_read_in && !avs_waitrequest_out && !mapped
        |-> avs_readdata_out == `SMP_UNMAPPED) else $error("unmapped read data wrong");
    AST_READ_HOLD: assert property ($changed(avs_readdata_out) |-> !avs_waitrequest_out)
        else $error("read data moved outside an answer");
    AST_ONE_RELEASE: assert property (!coil_one_pin_enable_out [*4] |->
        coil_one_plus_oe_n_out && coil_one_minus_oe_n_out) else $error("coil one pins driven");
    AST_TWO_RELEASE: assert property (!coil_two_pin_enable_out [*4] |->
        coil_two_plus_oe_n_out && coil_two_minus_oe_n_out) else $error("coil two pins driven");
endmodule
bind smp_top smp_top_asserts chk_i (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .coil_one_plus_oe_n_out(coil_one_plus_oe_n_out), .coil_one_minus_oe_n_out(coil_one_minus_oe_n_out),
    .coil_two_plus_oe_n_out(coil_two_plus_oe_n_out), .coil_two_minus_oe_n_out(coil_two_minus_oe_n_out),
    .coil_one_pin_enable_out(coil_one_pin_enable_out), .coil_two_pin_enable_out(coil_two_pin_enable_out)
);

// ### smp_coil_model.sv
// coil model: resolves the four coil driver pins
// assumes levels and active-low enables come from smp_top
`timescale 1ns/1ps
module smp_coil_model (
    input  wire [3:0] level_in,  // driven levels
    input  wire [3:0] oe_n_in,   // low while driven
    output wire [3:0] pin_out    // coil end levels
);
    reg [3:0] last = 4'h0;  // last driven level per pin
    // remember what each driver last put out
    always @(level_in or oe_n_in) last = (last & oe_n_in) | (level_in & ~oe_n_in);
    // a released end floats: show the inverse so a stale level never passes
    assign pin_out = (level_in & ~oe_n_in) | (~last & oe_n_in);
endmodule

// ### stepper_motor_pwm_selector_bench.sv
// bench of smp_top: register access, pulse timing, buffered loads, selector codes
// assumes smp_top, smp_coil_model and the checker are compiled beside it
`timescale 1ns/1ps
`include "smp_consts.vh"
module stepper_motor_pwm_selector_bench;
    // ********************************
    // signals
    // ********************************
    logic        clock_in    = 1'b0;   // 50 MHz
    logic        rst_in      = 1'b1;   // synchronous reset
    logic [7:0]  adr         = 8'h00;  // word index
    logic        rd          = 1'b0;   // read request
    logic        wr          = 1'b0;   // write request
    logic [31:0] wd          = 32'h0;  // write data
    wire  [31:0] rdat;                 // read data
    wire         wrq;                  // waitrequest
    wire  [3:0]  lv;                   // driven levels
    wire  [3:0]  oen;                  // low while driving
    wire  [3:0]  pin;                  // resolved coil ends
    wire         en1;                  // coil one pins enabled
    wire         en2;                  // coil two pins enabled
    integer      err_count   = 0;
    integer      check_count = 0;
    integer      n;
    integer      hi;
    integer      i;
    logic [31:0] rv;                   // last read value
    logic [31:0] rv2;                  // earlier read value
    logic [2:0]  codes [4]   = '{3'h0, 3'h1, 3'h4, 3'h7};
    always #10 clock_in = ~clock_in;
    smp_top uut (
        .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wrq),
        .coil_one_plus_output_out(lv[0]), .coil_one_plus_oe_n_out(oen[0]),
        .coil_one_minus_output_out(lv[1]), .coil_one_minus_oe_n_out(oen[1]),
        .coil_two_plus_output_out(lv[2]), .coil_two_plus_oe_n_out(oen[2]),
        .coil_two_minus_output_out(lv[3]), .coil_two_minus_oe_n_out(oen[3]),
        .coil_one_pin_enable_out(en1), .coil_two_pin_enable_out(en2));
    smp_coil_model coils (.level_in(lv), .oe_n_in(oen), .pin_out(pin));
    // ********************************
    // tasks
    // ********************************
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon cycle: hold until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        integer k;
        @(posedge clock_in);
        adr <= a;
        wd <= {24'h0, d};
        rd <= !w;
        wr <= w;
        k = 0;
        @(posedge clock_in);
        while (wrq !== 1'b0 && k < 20) begin
            @(posedge clock_in);
            k++;
        end
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 20) begin
            chk("bus_timeout", 32'h0, 32'h1);
            give_verdict;
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, e, rv);
    endtask
    // wait, bounded, until a coil end is sampled at level v
    task automatic wait_pin(input integer s, input logic v, output integer c);
        c = 0;
        while (pin[s] !== v && c < 9000) begin
            @(posedge clock_in);
            c++;
        end
        if (c >= 9000) begin
            chk("pin_timeout", 32'h0, 32'h1);
            give_verdict;
        end
    endtask
    // measure one full pulse of end s from its rising edge
    task automatic meas(input integer s, input integer eh, input integer et, input integer lag);
        integer lo;
        wait_pin(s, 1'b0, n);
        wait_pin(s, 1'b1, n);
        if (lag) begin
            chk("two_before", 32'h0, {31'h0, pin[2]});
            @(posedge clock_in);
            chk("two_after", 32'h1, {31'h0, pin[2]});
        end
        wait_pin(s, 1'b0, hi);
        wait_pin(s, 1'b1, lo);
        chk("high_time", eh, hi + lag);
        chk("period", et, hi + lag + lo);
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        rreg("control", `SMP_IDX_CONTROL, 32'h0);
        rreg("sel_one", `SMP_IDX_SEL_ONE, 32'h0);
        rreg("sel_two", `SMP_IDX_SEL_TWO, 32'h0);
        rreg("cmp_one", `SMP_IDX_CMP_ONE, 32'h0);
        rreg("test", `SMP_IDX_TEST, 32'h2);
        wreg(8'h30, 8'h55);
        rreg("unmapped", 8'h30, `SMP_UNMAPPED);
        wreg(`SMP_IDX_SEL_ONE, 8'hFF);
        rreg("sel_one_mask", `SMP_IDX_SEL_ONE, 32'h3F);
        wreg(`SMP_IDX_CONTROL, 8'hFE);
        rreg("control_mask", `SMP_IDX_CONTROL, 32'hF8);
        $display("register test done");
        // both coils pulse on the plus end, every prescale
        wreg(`SMP_IDX_CMP_ONE, 8'h80);
        wreg(`SMP_IDX_CMP_TWO, 8'h80);
        wreg(`SMP_IDX_SEL_ONE, 8'h10);
        wreg(`SMP_IDX_SEL_TWO, 8'h50);
        for (i = 0; i < 4; i++) begin
            wreg(`SMP_IDX_CONTROL, 8'(8'hC8 | (i << 4)));
            meas(0, 128 << i, 256 << i, 1);
        end
        $display("prescale test done");
        // halt holds the count, restart begins at zero
        wreg(`SMP_IDX_CONTROL, 8'hF0);
        bus(1'b0, `SMP_IDX_STATUS, 8'h00);
        rv2 = rv;
        repeat (20) @(posedge clock_in);
        bus(1'b0, `SMP_IDX_STATUS, 8'h00);
        chk("held_count", rv2, rv);
        chk("run_off", 32'h0, {31'h0, rv[8]});
        wreg(`SMP_IDX_CONTROL, 8'hF8);
        bus(1'b0, `SMP_IDX_STATUS, 8'h00);
        chk("restart", 32'h1, {31'h0, rv[8] && rv[7:0] < 8'h02});
        $display("run test done");
        // buffered compare and select loads
        wreg(`SMP_IDX_CONTROL, 8'hC8);
        meas(0, 128, 256, 1);
        wreg(`SMP_IDX_CMP_ONE, 8'h40);
        meas(0, 128, 256, 0);
        wreg(`SMP_IDX_CMP_TWO, 8'h20);
        wreg(`SMP_IDX_SEL_TWO, 8'h50);
        rreg("strobe_set", `SMP_IDX_SEL_TWO, 32'h50);
        meas(0, 64, 256, 0);
        rreg("strobe_clear", `SMP_IDX_SEL_TWO, 32'h10);
        meas(2, 32, 256, 0);
        wreg(`SMP_IDX_CMP_ONE, 8'hFF);
        wreg(`SMP_IDX_SEL_TWO, 8'h50);
        meas(0, 255, 256, 0);
        wreg(`SMP_IDX_CMP_ONE, 8'h00);
        wreg(`SMP_IDX_SEL_TWO, 8'h50);
        repeat (300) @(posedge clock_in);
        hi = 0;
        repeat (300) begin
            @(posedge clock_in);
            hi = hi + pin[0];
        end
        chk("zero_duty", 32'h0, hi);
        $display("buffer test done");
        // selector codes on both ends of coil one
        wreg(`SMP_IDX_CMP_ONE, 8'h80);
        for (i = 0; i < 4; i++) begin
            wreg(`SMP_IDX_SEL_ONE, {2'b00, codes[i], codes[i]});
            wreg(`SMP_IDX_SEL_TWO, 8'h50);
            repeat (300) @(posedge clock_in);
            chk("oe_plus", {31'h0, codes[i][2]}, {31'h0, oen[0]});
            chk("oe_minus", {31'h0, codes[i][2]}, {31'h0, oen[1]});
            if (!codes[i][2])
                chk("level", {31'h0, codes[i][0]}, {31'h0, pin[1]});
        end
        wreg(`SMP_IDX_SEL_ONE, 8'h03);
        wreg(`SMP_IDX_SEL_TWO, 8'h50);
        meas(1, 128, 256, 0);
        // pin enable hands coil one pins back
        wreg(`SMP_IDX_SEL_ONE, 8'h09);
        wreg(`SMP_IDX_SEL_TWO, 8'h50);
        wreg(`SMP_IDX_CONTROL, 8'h88);
        repeat (300) @(posedge clock_in);
        chk("pin_one_off", 32'h0, {31'h0, en1});
        chk("pin_two_on", 32'h1, {31'h0, en2});
        chk("two_driven", 32'h0, {29'h0, oen[3:2], pin[3]});
        chk("oe_released", 32'h3, {30'h0, oen[1:0]});
        wreg(`SMP_IDX_CONTROL, 8'hC8);
        repeat (10) @(posedge clock_in);
        chk("oe_driven", 32'h0, {30'h0, oen[1:0]});
        chk("pins_high", 32'h3, {30'h0, pin[1:0]});
        $display("selector test done");
        give_verdict;
    end
endmodule
